// *** hdl/siopc_pkg.sv ***
package siopc_pkg;

	// ----------------------------------------
	// register indices (byte address = 4 * index)
	// ----------------------------------------
	localparam logic [7:0] IDX_POLARITY = 8'h4D;
	localparam logic [7:0] IDX_TEACH = 8'h4F;
	localparam logic [7:0] IDX_PIN2 = 8'h50;
	localparam logic [7:0] IDX_PIN5 = 8'h51;
	localparam logic [7:0] IDX_PIN6 = 8'h52;
	localparam logic [7:0] IDX_PIN7 = 8'h53;
	localparam logic [7:0] IDX_STATUS = 8'h54;
	localparam int APB_AW = 12;
	localparam int NPIN = 4;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int TCH_STORE_POS = 16;
	localparam int TCH_SENS_LSB = 8;
	localparam int PIN_DIR_POS = 24;
	localparam int PIN_INV_POS = 16;
	localparam int PIN_IN_LSB = 8;
	localparam int PIN_OUT_LSB = 0;
	localparam int STAT_OE_LSB = 4;
	localparam int STAT_LVL_LSB = 16;

	// ----------------------------------------
	// encodings and reset values
	// ----------------------------------------
	localparam logic POL_SINK = 1'b0;
	localparam logic POL_SOURCE = 1'b1;
	localparam logic POL_RESET = POL_SOURCE;
	localparam logic STORE_NONVOL = 1'b0;
	localparam logic [1:0] SENS_HIGH_RES = 2'h0;
	localparam logic [1:0] SENS_MED_RES = 2'h1;
	localparam logic [1:0] SENS_LOW_RES = 2'h2;
	localparam logic DIR_OUT = 1'b0;
	localparam logic DIR_IN = 1'b1;
	localparam logic [1:0] IN_NONE = 2'h0;
	localparam logic [1:0] IN_TRIG = 2'h1;
	localparam logic [1:0] IN_TEACH = 2'h2;
	localparam logic [1:0] OUT_NONE = 2'h0;
	localparam logic [1:0] OUT_AREA = 2'h1;
	localparam logic [1:0] OUT_WARN = 2'h2;
	localparam logic [1:0] OUT_TRIG = 2'h3;

	typedef struct packed {
		logic dir;
		logic inv;
		logic [1:0] in_role;
		logic [1:0] out_role;
	} siopc_pin_s;

	typedef struct packed {
		logic vol;
		logic [1:0] sens;
	} siopc_teach_s;

	localparam siopc_pin_s PIN_RESET = '{DIR_OUT, 1'b0, IN_NONE, OUT_NONE};
	localparam siopc_teach_s TEACH_RESET = '{STORE_NONVOL, SENS_HIGH_RES};

	function automatic logic [31:0] pin_pack(siopc_pin_s p);
		logic [31:0] w;
		w = 32'h0;
		w[PIN_DIR_POS] = p.dir;
		w[PIN_INV_POS] = p.inv;
		w[PIN_IN_LSB +: 2] = p.in_role;
		w[PIN_OUT_LSB +: 2] = p.out_role;
		return w;
	endfunction

	function automatic siopc_pin_s pin_unpack(logic [31:0] w);
		return '{w[PIN_DIR_POS], w[PIN_INV_POS], w[PIN_IN_LSB +: 2], w[PIN_OUT_LSB +: 2]};
	endfunction

	// whole record must be in range; unused bits must be zero
	function automatic logic pin_word_ok(logic [31:0] w);
		return (pin_pack(pin_unpack(w)) == w) && (w[PIN_IN_LSB +: 2] <= IN_TEACH);
	endfunction

	function automatic logic [31:0] teach_pack(siopc_teach_s t);
		logic [31:0] w;
		w = 32'h0;
		w[TCH_STORE_POS] = t.vol;
		w[TCH_SENS_LSB +: 2] = t.sens;
		return w;
	endfunction

	function automatic logic teach_word_ok(logic [31:0] w);
		siopc_teach_s t;
		t = '{w[TCH_STORE_POS], w[TCH_SENS_LSB +: 2]};
		return (teach_pack(t) == w) && (t.sens <= SENS_LOW_RES);
	endfunction

endpackage

// *** hdl/siopc_top.sv ***
// Chosen here: the APB register port.
`timescale 1ns/1ns
module siopc_top
	import siopc_pkg::*;
#(
	parameter bit SERIAL_VARIANT = 1'b1,
	parameter logic [7:0] LVL_HIGH_RES = 8'h40,
	parameter logic [7:0] LVL_MED_RES = 8'h80,
	parameter logic [7:0] LVL_LOW_RES = 8'hC0
)
(
	// clock, reset, enable
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	// apb slave
	input wire logic [siopc_pkg::APB_AW-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// switching pins 2,5,6,7
	input wire logic [siopc_pkg::NPIN-1:0] pin_in,
	output logic [siopc_pkg::NPIN-1:0] pin_out,
	output logic [siopc_pkg::NPIN-1:0] pin_oe,
	// evaluation sources
	input wire logic [siopc_pkg::NPIN-1:0] area_sw,
	input wire logic warn_in,
	input wire logic trig_src_in,
	// teach and trigger events
	output logic trig_go,
	output logic teach_go,
	output logic [7:0] teach_level,
	output logic teach_volatile
);
	import siopc_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	localparam logic [NPIN-1:0] PIN_EN = SERIAL_VARIANT ? 4'hF : 4'h3;

	logic pol_reg;
	siopc_teach_s teach_reg;
	siopc_pin_s [NPIN-1:0] pin_reg;
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic [NPIN-1:0] pin_out_reg;
	logic [NPIN-1:0] pin_oe_reg;
	logic [NPIN-1:0] in_prev_reg;
	logic trig_go_reg;
	logic teach_go_reg;
	logic [7:0] level_reg;
	logic vol_reg;

	logic [7:0] sel;
	logic [1:0] pin_idx;
	logic acc_err;
	logic [31:0] rd_word;
	logic wr_go;
	logic [NPIN-1:0] in_act;
	logic [NPIN-1:0] out_src;
	logic [NPIN-1:0] drive;
	logic [NPIN-1:0] trig_edge;
	logic [NPIN-1:0] teach_edge;

	// higher reserve means a less sensitive threshold
	function automatic logic [7:0] sens_level(logic [1:0] s);
		unique case (s)
			SENS_MED_RES: return LVL_MED_RES;
			SENS_LOW_RES: return LVL_LOW_RES;
			default: return LVL_HIGH_RES;
		endcase
	endfunction

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	assign sel = paddr[9:2];
	assign pin_idx = 2'(sel - IDX_PIN2);

	always_comb
	begin
		acc_err = 1'b0;
		rd_word = 32'h0;
		unique case (sel)
			IDX_POLARITY:
			begin
				acc_err = pwrite && (!pstrb[0] || pwdata[7:1] != 7'h0);
				rd_word = {31'h0, pol_reg};
			end
			IDX_TEACH:
			begin
				acc_err = pwrite && (pstrb != 4'hF || !teach_word_ok(pwdata));
				rd_word = teach_pack(teach_reg);
			end
			IDX_PIN2, IDX_PIN5, IDX_PIN6, IDX_PIN7:
			begin
				acc_err = !PIN_EN[pin_idx] ||
					(pwrite && (pstrb != 4'hF || !pin_word_ok(pwdata)));
				rd_word = PIN_EN[pin_idx] ? pin_pack(pin_reg[pin_idx]) : 32'h0;
			end
			IDX_STATUS:
			begin
				acc_err = pwrite;
				rd_word = {8'h0, level_reg, 8'h0, pin_oe_reg, in_prev_reg};
			end
			default:
				acc_err = 1'b1;
		endcase
		if (paddr[1:0] != 2'h0 || paddr[APB_AW-1:10] != 2'h0)
		begin
			acc_err = 1'b1;
			rd_word = 32'h0;
		end
	end

	// answer is prepared in the setup cycle, so the access phase never waits
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0;
		end
		else if (ce)
		begin
			pready_reg <= psel && !penable;
			pslverr_reg <= psel && !penable && acc_err;
			prdata_reg <= (psel && !penable && !pwrite) ? rd_word : 32'h0;
		end
	end

	assign wr_go = ce && psel && penable && pready_reg && pwrite && !pslverr_reg;

	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			pol_reg <= POL_RESET;
		else if (wr_go && sel == IDX_POLARITY)
			pol_reg <= pwdata[0];
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			teach_reg <= TEACH_RESET;
		else if (wr_go && sel == IDX_TEACH)
			teach_reg <= '{pwdata[TCH_STORE_POS], pwdata[TCH_SENS_LSB +: 2]};
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			pin_reg <= {NPIN{PIN_RESET}};
		else if (wr_go && sel >= IDX_PIN2 && sel <= IDX_PIN7)
			pin_reg[pin_idx] <= pin_unpack(pwdata);
	end

	// ----------------------------------------
	// pin behaviour
	// ----------------------------------------
	always_comb
	begin
		for (int i = 0; i < NPIN; i++)
		begin
			// sinking inputs are active when pulled low
			in_act[i] = (pin_in[i] == pol_reg) ^ pin_reg[i].inv;
			unique case (pin_reg[i].out_role)
				OUT_AREA: out_src[i] = area_sw[i];
				OUT_WARN: out_src[i] = warn_in;
				OUT_TRIG: out_src[i] = trig_src_in;
				default: out_src[i] = 1'b0;
			endcase
			drive[i] = PIN_EN[i] && pin_reg[i].dir == DIR_OUT &&
				pin_reg[i].out_role != OUT_NONE && (out_src[i] ^ pin_reg[i].inv);
			trig_edge[i] = PIN_EN[i] && pin_reg[i].dir == DIR_IN &&
				pin_reg[i].in_role == IN_TRIG && in_act[i] && !in_prev_reg[i];
			teach_edge[i] = PIN_EN[i] && pin_reg[i].dir == DIR_IN &&
				pin_reg[i].in_role == IN_TEACH && in_act[i] && !in_prev_reg[i];
		end
	end

	// open-collector style: the active level is driven, the idle level is released
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pin_out_reg <= {NPIN{POL_RESET}};
			pin_oe_reg <= '0;
			in_prev_reg <= '0;
		end
		else if (ce)
		begin
			pin_out_reg <= {NPIN{pol_reg}};
			pin_oe_reg <= drive;
			in_prev_reg <= in_act & PIN_EN;
		end
	end

	// ----------------------------------------
	// teach and trigger events
	// ----------------------------------------
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			trig_go_reg <= 1'b0;
			teach_go_reg <= 1'b0;
			level_reg <= LVL_HIGH_RES;
			vol_reg <= STORE_NONVOL;
		end
		else if (ce)
		begin
			trig_go_reg <= |trig_edge;
			teach_go_reg <= |teach_edge;
			vol_reg <= teach_reg.vol;
			if (|teach_edge)
				level_reg <= sens_level(teach_reg.sens);
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign pin_out = pin_out_reg;
	assign pin_oe = pin_oe_reg;
	assign trig_go = trig_go_reg;
	assign teach_go = teach_go_reg;
	assign teach_level = level_reg;
	assign teach_volatile = vol_reg;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	store_sel_a: assert property (
		wr_go && sel == IDX_TEACH ##1 ce |=> teach_volatile == $past(pwdata[TCH_STORE_POS], 2))
		else $error("storage selector output does not follow the teach record");

	sens_range_a: assert property (teach_reg.sens <= SENS_LOW_RES)
		else $error("sensitivity field out of range");

	reserve_order_a: assert property (
		teach_go && teach_reg.sens == SENS_LOW_RES && $stable(teach_reg) |->
		teach_level == LVL_LOW_RES && LVL_LOW_RES > LVL_HIGH_RES)
		else $error("teach threshold does not follow the reserve");

	drive_style_a: assert property (
		ce && $past(ce) && pin_oe[1] |-> pin_out[1] == $past(pol_reg))
		else $error("drive style differs from polarity");

	variant_pins_a: assert property (
		(pin_oe & ~PIN_EN) == '0 && (trig_go -> $past(|(trig_edge & PIN_EN))))
		else $error("absent pin is active");

	invert_out_a: assert property (
		ce && pin_reg[2].dir == DIR_OUT && pin_reg[2].out_role == OUT_WARN &&
		(warn_in ^ pin_reg[2].inv) |=> pin_oe[2])
		else $error("inverted output not driven");

	in_role_a: assert property (
		ce && teach_go |-> $past(pin_reg[0].in_role == IN_TEACH || pin_reg[1].in_role == IN_TEACH ||
		pin_reg[2].in_role == IN_TEACH || pin_reg[3].in_role == IN_TEACH))
		else $error("teach event without a teach input");

	out_role_a: assert property (
		ce && pin_oe[1] |-> $past(pin_reg[1].out_role) != OUT_NONE)
		else $error("inactive output role drives");

	dir_sel_a: assert property (
		ce && pin_reg[1].dir == DIR_IN |=> !pin_oe[1])
		else $error("input pin drives");

	whole_rec_a: assert property (
		psel && !penable && pwrite && sel == IDX_PIN2 && pstrb != 4'hF && ce ##1
		psel && penable && ce |-> pslverr ##1 pin_reg[0] == $past(pin_reg[0]))
		else $error("partial record write accepted");

	teach_evt_c: cover property (teach_go);
	trig_evt_c: cover property (trig_go);
	refused_c: cover property (pready && pslverr && pwrite);
	drive_c: cover property (pin_oe[1] && pin_out[1] == POL_SINK);

endmodule

// *** verif/siopc_ctrl_model.sv ***
`timescale 1ns/1ns
module siopc_ctrl_model
	import siopc_pkg::*;
(
	// clock
	input wire logic clk,
	// device pins
	input wire logic [siopc_pkg::NPIN-1:0] pin_out,
	input wire logic [siopc_pkg::NPIN-1:0] pin_oe,
	// controller drive
	input wire logic [siopc_pkg::NPIN-1:0] ctl_en,
	input wire logic [siopc_pkg::NPIN-1:0] ctl_lvl,
	output logic [siopc_pkg::NPIN-1:0] pin_in
);
	import siopc_pkg::*;

	logic [NPIN-1:0] last_reg;

	// a wire nobody drives shows the inverse of its last level, so a stale value never passes
	always_comb
	begin
		pin_in = (pin_oe & pin_out) | (~pin_oe & ctl_en & ctl_lvl) | (~pin_oe & ~ctl_en & ~last_reg);
	end

	always_ff @(posedge clk)
	begin
		last_reg <= pin_in;
	end
endmodule

// *** verif/siopc_top_tb.sv ***
`timescale 1ns/1ns
module siopc_top_tb;
	import siopc_pkg::*;
	localparam logic [7:0] LVL_TAB [3] = '{8'h40, 8'h80, 8'hC0};
	logic clk, arst_n, ce, psel, penable, pwrite, pready, pslverr, er;
	logic warn_in, trig_src_in, trig_go, teach_go, teach_volatile;
	logic [APB_AW-1:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic [NPIN-1:0] pin_in, pin_out, pin_oe, area_sw, ctl_lvl;
	logic [7:0] teach_level;
	int n_fail, n_compared, t, g;

	siopc_top #(.SERIAL_VARIANT(1'b1), .LVL_HIGH_RES(LVL_TAB[0]), .LVL_MED_RES(LVL_TAB[1]),
		.LVL_LOW_RES(LVL_TAB[2])) siopc_top_inst (
		.clk(clk), .arst_n(arst_n), .ce(ce), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.area_sw(area_sw), .warn_in(warn_in), .trig_src_in(trig_src_in), .trig_go(trig_go),
		.teach_go(teach_go), .teach_level(teach_level), .teach_volatile(teach_volatile));

	siopc_ctrl_model siopc_ctrl_model_inst (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
		.ctl_en(4'hF), .ctl_lvl(ctl_lvl), .pin_in(pin_in));

	// ----------------------------------------
	// bus and compare helpers
	// ----------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task apb(input logic w, input logic [7:0] idx, input logic [31:0] d, input logic [3:0] s);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= d;
		pstrb <= s;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		// no cycle limit here: only the watchdog ends a wait that never answers
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk(n, 32'h1);
	endtask

	task wr(input logic [7:0] idx, input logic [31:0] d);
		apb(1'b1, idx, d, 4'hF);
		chk(er, 1'b0);
	endtask

	task rd_chk(input logic [7:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0, 4'hF);
		chk(rd, exp);
	endtask

	task pulses;
		t = 0;
		g = 0;
		repeat (5)
		begin
			@(negedge clk);
			t += (trig_go === 1'b1);
			g += (teach_go === 1'b1);
		end
	endtask

	task set_src(input logic a, input logic w, input logic s);
		@(posedge clk);
		area_sw <= {2'h0, a, 1'b0};
		warn_in <= w;
		trig_src_in <= s;
		repeat (3) @(posedge clk);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_reset;
		chk(pin_out, 4'hF);
		chk(pin_oe, 4'h0);
		chk(teach_volatile, 1'b0);
		chk(teach_level, LVL_TAB[0]);
		rd_chk(IDX_POLARITY, 32'h1);
		rd_chk(IDX_TEACH, 32'h0);
		for (int i = 0; i < 4; i++)
			rd_chk(8'(IDX_PIN2 + i), 32'h0);
	endtask

	task automatic t_refuse;
		// the last entry is a valid pin record sent with a partial strobe
		logic [7:0] ix [7] = '{8'h4E, IDX_TEACH, IDX_TEACH, IDX_PIN2, IDX_PIN2, IDX_STATUS,
			IDX_PIN2};
		logic [31:0] dv [7] = '{32'h1, 32'h300, 32'h100, 32'h300, 32'h4, 32'h1, 32'h1};
		logic [3:0] sv [7] = '{4'hF, 4'hF, 4'h7, 4'hF, 4'hF, 4'hF, 4'h3};
		for (int i = 0; i < 7; i++)
		begin
			apb(1'b1, ix[i], dv[i], sv[i]);
			chk(er, 1'b1);
		end
		rd_chk(8'h4E, 32'h0);
		rd_chk(IDX_TEACH, 32'h0);
		rd_chk(IDX_PIN2, 32'h0);
	endtask

	task t_teach;
		wr(IDX_PIN2, 32'h0100_0200);
		for (int s = 0; s < 3; s++)
		begin
			// storage stays non-volatile except in one pass
			wr(IDX_TEACH, (32'(s) << 8) | ((s == 1) ? 32'h1_0000 : 32'h0));
			@(posedge clk);
			ctl_lvl[0] <= 1'b1;
			pulses();
			chk(g, 1);
			chk(teach_level, LVL_TAB[s]);
			chk(teach_volatile, s == 1);
			@(posedge clk);
			ctl_lvl[0] <= 1'b0;
			repeat (2) @(posedge clk);
		end
		wr(IDX_PIN2, 32'h0101_0200);
		pulses();
		chk(g, 1);
		wr(IDX_PIN2, 32'h0000_0200);
		@(posedge clk);
		ctl_lvl[0] <= 1'b1;
		pulses();
		chk(g, 0);
	endtask

	task t_outputs;
		for (int r = 1; r < 4; r++)
		begin
			wr(IDX_PIN5, 32'(r));
			set_src(r != 1, r != 2, r != 3);
			chk(pin_oe, 4'h0);
			set_src(r == 1, r == 2, r == 3);
			chk(pin_oe, 4'h2);
			chk(pin_out[1], 1'b1);
		end
		wr(IDX_POLARITY, 32'h0);
		wr(IDX_PIN5, 32'h1);
		set_src(1'b1, 1'b0, 1'b0);
		chk(pin_out[1], 1'b0);
		wr(IDX_PIN5, 32'h0100_0001);
		repeat (2) @(posedge clk);
		chk(pin_oe, 4'h0);
		wr(IDX_POLARITY, 32'h1);
		set_src(1'b0, 1'b0, 1'b0);
	endtask

	task t_trig;
		wr(IDX_PIN6, 32'h0001_0002);
		rd_chk(IDX_PIN6, 32'h0001_0002);
		chk(pin_oe, 4'h4);
		wr(IDX_PIN7, 32'h0100_0100);
		rd_chk(IDX_PIN7, 32'h0100_0100);
		@(posedge clk);
		ctl_lvl[3] <= 1'b1;
		pulses();
		chk(t, 1);
		chk(g, 0);
	endtask

	task complete_run;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// hang guard: the whole sequence needs well under a thousand cycles
	initial
	begin
		repeat (5000) @(posedge clk);
		n_fail++;
		complete_run();
	end

	initial
	begin
		{arst_n, psel, penable, pwrite, warn_in, trig_src_in} = '0;
		ce = 1'b1;
		paddr = '0;
		pwdata = '0;
		pstrb = '0;
		area_sw = '0;
		ctl_lvl = '0;
		n_fail = 0;
		n_compared = 0;
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		t_reset();
		t_refuse();
		t_teach();
		t_outputs();
		t_trig();
		complete_run();
	end
endmodule
